// ### rtl/ais_pkg.sv
// Constants and types shared by the sequencer 0 input select block
`default_nettype none
package ais_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_START  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_STIME  = 12'h00c;
  localparam logic [11:0] OFS_SEL    = 12'h040;
  localparam logic [11:0] OFS_SCTL   = 12'h044;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          SLOTS       = 8;
  localparam int          SLOT_STRIDE = 4;
  localparam int          CODE_W      = 2;
  localparam int          TS_POS      = 3;
  localparam logic [31:0] SEL_WMASK   = 32'h33333333;
  localparam logic [31:0] SCTL_WMASK  = 32'h88888888;
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_CONT   = 1;
  localparam int          CTRL_LAST   = 4;
  localparam int          START_GO    = 0;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_SLOT   = 4;
  localparam int          STAT_OVR    = 8;
  localparam int          STAT_CNT    = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SEL_RST   = 32'h00000000;
  localparam logic [31:0] SCTL_RST  = 32'h00000000;
  localparam logic [7:0]  CTRL_RST  = 8'h70;
  localparam logic [7:0]  STIME_RST = 8'h04;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AIS_IDLE    = 3'b001,
    AIS_SAMPLE  = 3'b010,
    AIS_CONVERT = 3'b100
  } ais_state_t;

endpackage
`default_nettype wire

// ### rtl/ais_slot_mux.sv
// Per-slot field extraction and selection for the current slot
`default_nettype none
module ais_slot_mux (
  input  wire logic [31:0] sel_reg,
  input  wire logic [31:0] sctl_reg,
  input  wire logic [2:0]  slot,
  output logic      [1:0]  code,
  output logic             temp_sel
);

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  logic [1:0] codes [ais_pkg::SLOTS];
  logic       tsel  [ais_pkg::SLOTS];

  // Slot n takes bits 4n-3:4n-4, so slot one is 1:0 and slot eight 29:28
  for (genvar i = 0; i < ais_pkg::SLOTS; i++) begin : g_slot
    assign codes[i] = sel_reg[i*ais_pkg::SLOT_STRIDE +: ais_pkg::CODE_W];
    assign tsel[i]  = sctl_reg[i*ais_pkg::SLOT_STRIDE + ais_pkg::TS_POS];
  end

  assign code     = codes[slot];
  assign temp_sel = tsel[slot];

endmodule
`default_nettype wire

// ### rtl/ais_sample_timer.sv
// Down counter that times the sampling period of one slot
`default_nettype none
module ais_sample_timer (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] period,
  output logic            done
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       run_q;
  logic       run_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A period of zero would wrap and run 256 cycles, so it is stretched to one
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (load) begin
      cnt_d = (period == 8'h00) ? 8'h01 : period;
      run_d = 1'b1;
    end else if (run_q) begin
      cnt_d = cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        run_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign done = run_q && (cnt_q == 8'h01) && !load;

endmodule
`default_nettype wire

// ### rtl/ais_top.sv
// Sequencer 0 input select: APB registers and slot stepping
//
// Contract
// - One 32-bit input select register, eight slots
// - Slot one uses bits 1:0
// - Slot two uses bits 5:4
// - Slot three uses bits 9:8
// - Slot four uses bits 13:12
// - Slot five uses bits 17:16
// - Slot six uses bits 21:20
// - Slot seven bits 25:24, slot eight 29:28
// - Select fields read/write, reset to zero
// - Upper two bits per group read zero
// - Temp sensor bit overrides the slot input; here it only drives temp_sensor_sel, and ain_code keeps the slot code
`default_nettype none
module ais_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        seq_trigger,
  input  wire logic        conv_done,
  output logic      [1:0]  ain_code,
  output logic             temp_sensor_sel,
  output logic             sample_hold,
  output logic             conv_start,
  output logic      [2:0]  slot_index,
  output logic             seq_busy
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] sel_q;
  logic [31:0] sel_d;
  logic [31:0] sctl_q;
  logic [31:0] sctl_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  stime_q;
  logic [7:0]  stime_d;
  logic        ovr_q;
  logic        ovr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  ais_pkg::ais_state_t state_q;
  ais_pkg::ais_state_t state_d;
  logic [2:0]  slot_q;
  logic [2:0]  slot_d;
  logic [1:0]  code_q;
  logic [1:0]  code_d;
  logic        ts_q;
  logic        ts_d;
  logic [7:0]  seqcnt_q;
  logic [7:0]  seqcnt_d;
  logic        cstart_q;
  logic        cstart_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_start;
  logic        hit_status;
  logic        hit_stime;
  logic        hit_sel;
  logic        hit_sctl;
  logic        hit_any;
  logic        sw_go;
  logic        start_req;
  logic        ovr_clr;
  logic        tmr_load;
  logic        tmr_done;
  logic [1:0]  mux_code;
  logic        mux_ts;
  logic [2:0]  last_slot;

  assign setup      = psel && !penable;
  assign wr_en      = psel && penable && pready_q && pwrite;
  assign hit_ctrl   = (paddr == ais_pkg::OFS_CTRL);
  assign hit_start  = (paddr == ais_pkg::OFS_START);
  assign hit_status = (paddr == ais_pkg::OFS_STATUS);
  assign hit_stime  = (paddr == ais_pkg::OFS_STIME);
  assign hit_sel    = (paddr == ais_pkg::OFS_SEL);
  assign hit_sctl   = (paddr == ais_pkg::OFS_SCTL);
  assign hit_any    = hit_ctrl || hit_start || hit_status || hit_stime ||
                      hit_sel || hit_sctl;
  assign sw_go      = wr_en && hit_start && pwdata[ais_pkg::START_GO];
  assign ovr_clr    = wr_en && hit_status && pwdata[ais_pkg::STAT_OVR];
  assign start_req  = (seq_trigger || sw_go) && ctrl_q[ais_pkg::CTRL_EN];
  assign last_slot  = ctrl_q[ais_pkg::CTRL_LAST +: 3];

  // ----------------------------------------------------------------
  // Registers and APB answer
  // ----------------------------------------------------------------
  // Answer is prepared in the setup cycle so read data leaves a flop;
  // the cost is one fixed access cycle on every transfer.
  always_comb begin
    sel_d     = sel_q;
    sctl_d    = sctl_q;
    ctrl_d    = ctrl_q;
    stime_d   = stime_q;
    prdata_d  = prdata_q;
    pready_d  = setup;
    pslverr_d = 1'b0;
    ovr_d     = ovr_q;
    if (wr_en && hit_sel) begin
      sel_d = pwdata & ais_pkg::SEL_WMASK;
    end
    if (wr_en && hit_sctl) begin
      sctl_d = pwdata & ais_pkg::SCTL_WMASK;
    end
    if (wr_en && hit_ctrl) begin
      ctrl_d = pwdata[7:0] & 8'h73;
    end
    if (wr_en && hit_stime) begin
      stime_d = pwdata[7:0];
    end
    // A trigger in the clearing cycle while the sequencer is busy keeps the flag set
    if (ovr_clr) begin
      ovr_d = 1'b0;
    end
    if (start_req && (state_q != ais_pkg::AIS_IDLE)) begin
      ovr_d = 1'b1;
    end
    if (setup) begin
      pslverr_d = !hit_any;
      prdata_d  = 32'h00000000;
      if (!pwrite) begin
        if (hit_sel) begin
          prdata_d = sel_q & ais_pkg::SEL_WMASK;
        end
        if (hit_sctl) begin
          prdata_d = sctl_q;
        end
        if (hit_ctrl) begin
          prdata_d[7:0] = ctrl_q;
        end
        if (hit_stime) begin
          prdata_d[7:0] = stime_q;
        end
        if (hit_status) begin
          prdata_d[ais_pkg::STAT_BUSY]     = seq_busy;
          prdata_d[ais_pkg::STAT_SLOT +: 3] = slot_q;
          prdata_d[ais_pkg::STAT_OVR]      = ovr_q;
          prdata_d[ais_pkg::STAT_CNT +: 8] = seqcnt_q;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q     <= ais_pkg::SEL_RST;
      sctl_q    <= ais_pkg::SCTL_RST;
      ctrl_q    <= ais_pkg::CTRL_RST;
      stime_q   <= ais_pkg::STIME_RST;
      ovr_q     <= 1'b0;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      sel_q     <= sel_d;
      sctl_q    <= sctl_d;
      ctrl_q    <= ctrl_d;
      stime_q   <= stime_d;
      ovr_q     <= ovr_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Slot selection and sampling timer
  // ----------------------------------------------------------------
  ais_slot_mux u_mux (
    .sel_reg  (sel_q),
    .sctl_reg (sctl_q),
    .slot     (slot_d),
    .code     (mux_code),
    .temp_sel (mux_ts)
  );

  ais_sample_timer u_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .period  (stime_q),
    .done    (tmr_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // The code is latched only on entry to a slot, so a register write
  // in mid-slot cannot disturb the multiplexer while it samples.
  always_comb begin
    state_d  = state_q;
    slot_d   = slot_q;
    code_d   = code_q;
    ts_d     = ts_q;
    seqcnt_d = seqcnt_q;
    cstart_d = 1'b0;
    tmr_load = 1'b0;
    unique case (state_q)
      ais_pkg::AIS_IDLE: begin
        if (start_req) begin
          slot_d   = 3'h0;
          state_d  = ais_pkg::AIS_SAMPLE;
          tmr_load = 1'b1;
        end
      end
      ais_pkg::AIS_SAMPLE: begin
        if (tmr_done) begin
          state_d  = ais_pkg::AIS_CONVERT;
          cstart_d = 1'b1;
        end
      end
      ais_pkg::AIS_CONVERT: begin
        if (conv_done) begin
          if (slot_q == last_slot) begin
            seqcnt_d = seqcnt_q + 8'h01;
            if (ctrl_q[ais_pkg::CTRL_CONT] && ctrl_q[ais_pkg::CTRL_EN]) begin
              slot_d   = 3'h0;
              state_d  = ais_pkg::AIS_SAMPLE;
              tmr_load = 1'b1;
            end else begin
              state_d = ais_pkg::AIS_IDLE;
            end
          end else begin
            slot_d   = slot_q + 3'h1;
            state_d  = ais_pkg::AIS_SAMPLE;
            tmr_load = 1'b1;
          end
        end
      end
      default: begin
        state_d = ais_pkg::AIS_IDLE;
      end
    endcase
    if (tmr_load) begin
      code_d = mux_code;
      ts_d   = mux_ts;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ais_pkg::AIS_IDLE;
      slot_q   <= 3'h0;
      code_q   <= 2'h0;
      ts_q     <= 1'b0;
      seqcnt_q <= 8'h00;
      cstart_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      slot_q   <= slot_d;
      code_q   <= code_d;
      ts_q     <= ts_d;
      seqcnt_q <= seqcnt_d;
      cstart_q <= cstart_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign ain_code        = code_q;
  assign temp_sensor_sel = ts_q;
  assign sample_hold     = (state_q == ais_pkg::AIS_SAMPLE);
  assign conv_start      = cstart_q;
  assign slot_index      = slot_q;
  assign seq_busy        = (state_q != ais_pkg::AIS_IDLE);

endmodule
`default_nettype wire

// ### tb/ais_conv_model.sv
// Converter model: answers each conv_start with a delayed conv_done
`default_nettype none
module ais_conv_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       conv_start,
  input  wire logic [3:0] dly,
  output var  logic       conv_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q, cnt_d;
  logic       run_q, run_d, done_d;
  // Answers only after a request, never spontaneously
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (conv_start) begin
      cnt_d = dly;
      run_d = 1'b1;
    end else if (run_q && cnt_q == 4'h0) begin
      run_d  = 1'b0;
      done_d = 1'b1;
    end else if (run_q) begin
      cnt_d = cnt_q - 4'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 4'h0;
      run_q     <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      run_q     <= run_d;
      conv_done <= done_d;
    end
  end
endmodule
`default_nettype wire

// ### tb/ais_top_asserts.sv
// Port checks for the sequencer 0 input select block
`default_nettype none
module ais_top_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        seq_trigger,
  input wire logic        conv_done,
  input wire logic [1:0]  ain_code,
  input wire logic        temp_sensor_sel,
  input wire logic        sample_hold,
  input wire logic        conv_start,
  input wire logic [2:0]  slot_index,
  input wire logic        seq_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadows of the written registers; writes during a slot are not modelled
  logic [31:0] sel_q, sel_d, sctl_q, sctl_d;
  logic        wr;
  always_comb begin
    wr     = psel && penable && pready && pwrite && !pslverr;
    sel_d  = (wr && paddr == ais_pkg::OFS_SEL) ? pwdata : sel_q;
    sctl_d = (wr && paddr == ais_pkg::OFS_SCTL) ? pwdata : sctl_q;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q  <= 32'h0;
      sctl_q <= 32'h0;
    end else begin
      sel_q  <= sel_d;
      sctl_q <= sctl_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_setup_then_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error response carries data");
  a_sel_readback: assert property (pready && !pwrite && !pslverr &&
    paddr == ais_pkg::OFS_SEL |-> prdata == (sel_q & ais_pkg::SEL_WMASK))
    else $error("select readback wrong");
  a_first_slot_zero: assert property ($rose(sample_hold) &&
    !$past(seq_busy) |-> slot_index == 3'h0)
    else $error("sequence did not start at slot one");
  a_slot_code_map: assert property ($rose(sample_hold) |->
    ain_code == sel_q[4*slot_index +: 2])
    else $error("slot input code wrong");
  a_temp_sel_map: assert property ($rose(sample_hold) |->
    temp_sensor_sel == sctl_q[4*slot_index+3])
    else $error("temp sensor select wrong");
  a_code_held: assert property (seq_busy && !$rose(sample_hold) |->
    $stable(ain_code) && $stable(temp_sensor_sel) && $stable(slot_index))
    else $error("input code moved within a slot");
  a_conv_after_hold: assert property (conv_start |->
    $past(sample_hold) && !sample_hold ##1 !conv_start)
    else $error("convert pulse out of place");
  c_last_slot: cover property ($rose(sample_hold) && slot_index == 3'h7);
  c_err_resp: cover property (pready && pslverr);
  c_temp_slot: cover property (sample_hold && temp_sensor_sel);
endmodule
bind ais_top ais_top_asserts u_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .seq_trigger(seq_trigger), .conv_done(conv_done), .ain_code(ain_code),
  .temp_sensor_sel(temp_sensor_sel), .sample_hold(sample_hold),
  .conv_start(conv_start), .slot_index(slot_index), .seq_busy(seq_busy));
`default_nettype wire

// ### tb/adc_sequence_input_select_bench.sv
// Self-checking bench for the sequencer 0 input select block
`default_nettype none
module adc_sequence_input_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, rst_n = 1'b0, seq_trigger = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd, sel, sctl, prdata, exp_st;
  logic [3:0]  dly = 4'h0;
  logic        er, pready, pslverr, conv_done, temp_sensor_sel;
  logic        sample_hold, conv_start, seq_busy;
  logic [1:0]  ain_code;
  logic [2:0]  slot_index;
  int          n_mismatch = 0, comparisons = 0, cycles = 0, i;
  ais_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_trigger(seq_trigger), .conv_done(conv_done), .ain_code(ain_code),
    .temp_sensor_sel(temp_sensor_sel), .sample_hold(sample_hold),
    .conv_start(conv_start), .slot_index(slot_index), .seq_busy(seq_busy));
  ais_conv_model u_conv (.clk_sys(clk_sys), .rst_n(rst_n),
    .conv_start(conv_start), .dly(dly), .conv_done(conv_done));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // Request held until pready is seen high at a rising edge; only the
  // bench timeout ends a wait that never gets its answer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input logic want, input logic which);
    i = 0;
    @(negedge clk_sys);
    while ((which ? seq_busy : conv_start) !== want && i < 200) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 200) begin
      n_mismatch++;
    end
  endtask
  function automatic logic [31:0] slot_code(logic [31:0] s, int k);
    return {30'h0, s[4*k +: 2]};
  endfunction
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(79));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, ais_pkg::OFS_SEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int n = 0; n < 6; n++) begin
      apb(1'b0, ais_pkg::OFS_SEL, 32'h0);
      sel = (rd & ~ais_pkg::SEL_WMASK) | ($urandom() & ais_pkg::SEL_WMASK);
      if (n == 0) sel = 32'hffffffff; // Reserved ones must be dropped
      sctl = $urandom();
      apb(1'b1, ais_pkg::OFS_SEL, sel);
      apb(1'b0, ais_pkg::OFS_SEL, 32'h0);
      chk(rd, sel & ais_pkg::SEL_WMASK);
      apb(1'b1, ais_pkg::OFS_SCTL, sctl);
      apb(1'b1, ais_pkg::OFS_STIME, 32'($urandom_range(0, 3)));
      apb(1'b1, ais_pkg::OFS_CTRL, 32'h71);
      dly <= 4'($urandom_range(0, 9));
      if (n % 2 == 1) begin
        @(posedge clk_sys);
        // Second high cycle lands while busy and must flag an overrun
        seq_trigger <= 1'b1;
        repeat (2) @(posedge clk_sys);
        seq_trigger <= 1'b0;
      end else begin
        apb(1'b1, ais_pkg::OFS_START, 32'h1);
      end
      for (int k = 0; k < 8; k++) begin
        wait_for(1'b1, 1'b0);
        chk({29'h0, slot_index}, 32'(k));
        chk({30'h0, ain_code}, slot_code(sel, k));
        chk({31'h0, temp_sensor_sel}, {31'h0, sctl[4*k+3]});
      end
      wait_for(1'b0, 1'b1);
      chk({31'h0, seq_busy}, 32'h0);
      apb(1'b0, ais_pkg::OFS_STATUS, 32'h0);
      exp_st = (32'(n + 1) << ais_pkg::STAT_CNT) |
               (32'(n % 2) << ais_pkg::STAT_OVR) | (32'h7 << ais_pkg::STAT_SLOT);
      chk(rd, exp_st);
      apb(1'b1, ais_pkg::OFS_STATUS, 32'h1 << ais_pkg::STAT_OVR);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
